// ---- ycr_converter.sv ----
// top: self-path ycbcr 4:2:2 to rgb converter with bypass
`timescale 1ns/1ns
module ycr_converter #(
   parameter int FIFO_DEPTH = ycr_pkg::YCR_FIFO_DEPTH
)(
   input wire logic i_clk_sys,
   input wire logic i_rst_b,
   input wire ycr_pkg::ycr_mode_t i_mode,
   input wire logic i_in_valid,
   output logic o_in_ack,
   input wire logic [7:0] i_in_luma,
   input wire logic [7:0] i_in_chroma,
   input wire logic i_in_cr_phase,
   output logic o_luma_valid,
   input wire logic i_luma_ack,
   output logic [23:0] o_selfpath_luma_port,
   output logic o_chroma_valid,
   output logic [7:0] o_selfpath_chroma_port
);
   import ycr_pkg::*;
   initial
   begin
      if (FIFO_DEPTH < 2) $error("fifo depth too small");
   end

   // saturating scale-back of one fixed point product sum
   function automatic logic [7:0] sat8(input logic signed [23:0] acc);
      logic signed [23:0] v;
      v = (acc + YCR_ROUND) >>> YCR_FRAC;
      if (v < 0) sat8 = 8'h00;
      else if (v > YCR_MAX) sat8 = 8'hff;
      else sat8 = v[7:0];
   endfunction

   // coefficient product widened first so the sum cannot wrap at operand width
   function automatic logic signed [23:0] mulk(input logic signed [9:0] d, input logic signed [12:0] k);
      mulk = 24'(d) * 24'(k);
   endfunction

   // held chroma of the previous pixel; cb/cr alternate on the chroma lane
   logic [7:0] cb_r;
   logic [7:0] cr_r;
   logic take;
   logic [7:0] cb_now;
   logic [7:0] cr_now;
   assign cb_now = i_in_cr_phase ? cb_r : i_in_chroma;
   assign cr_now = i_in_cr_phase ? i_in_chroma : cr_r;

   // the fifo holds the luma word and the chroma byte; the chroma byte is shown in bypass only
   logic fifo_in_ready;
   logic fifo_out_valid;
   logic [31:0] fifo_out;
   assign o_in_ack = fifo_in_ready;
   assign take = i_in_valid && fifo_in_ready;

   always_ff @(posedge i_clk_sys or negedge i_rst_b)
   begin
      if (!i_rst_b)
      begin
         cb_r <= YCR_CHROMA_RST;
         cr_r <= YCR_CHROMA_RST;
      end
      else if (take)
      begin
         if (i_in_cr_phase) cr_r <= i_in_chroma;
         else cb_r <= i_in_chroma;
      end
   end

   // signed offsets from the nominal black and zero-chroma points
   wire signed [9:0] y_d = $signed({2'b00, i_in_luma}) - YCR_Y_OFS;
   wire signed [9:0] cb_d = $signed({2'b00, cb_now}) - YCR_C_OFS;
   wire signed [9:0] cr_d = $signed({2'b00, cr_now}) - YCR_C_OFS;
   wire signed [23:0] y_t = mulk(y_d, YCR_K_Y);
   wire signed [23:0] r_acc = y_t + mulk(cr_d, YCR_K_RCR);
   wire signed [23:0] g_acc = y_t - mulk(cr_d, YCR_K_GCR) - mulk(cb_d, YCR_K_GCB);
   wire signed [23:0] b_acc = y_t + mulk(cb_d, YCR_K_BCB);
   wire [7:0] r8 = sat8(r_acc);
   wire [7:0] g8 = sat8(g_acc);
   wire [7:0] b8 = sat8(b_acc);

   // format packing: 666 and 565 clip low bits of the 888 result
   wire [23:0] pk888 = {r8, g8, b8};
   wire [23:0] pk666 = {6'h00, r8[7:2], g8[7:2], b8[7:2]};
   wire [23:0] pk565 = {8'h00, r8[7:3], g8[7:2], b8[7:3]};
   wire [23:0] pk_byp = {16'h0000, i_in_luma};
   wire [23:0] luma_word = (i_mode == YCR_MODE_888) ? pk888 :
                           (i_mode == YCR_MODE_666) ? pk666 :
                           (i_mode == YCR_MODE_565) ? pk565 : pk_byp;
   wire chroma_on = (i_mode == YCR_MODE_BYPASS);
   wire [31:0] fifo_in = {chroma_on, i_in_chroma, luma_word[22:0]};
   logic top_bit;
   // bit 23 rides separately because fifo_in is only 32 wide
   logic [31:0] fifo_pair;

   ycr_fifo #(.WIDTH(33), .DEPTH(FIFO_DEPTH)) u_fifo (
      .i_clk_sys(i_clk_sys),
      .i_rst_b(i_rst_b),
      .i_in_valid(i_in_valid),
      .o_in_ready(fifo_in_ready),
      .i_in_data({luma_word[23], fifo_in}),
      .o_out_valid(fifo_out_valid),
      .i_out_ready(i_luma_ack),
      .o_out_data({top_bit, fifo_pair})
   );
   assign fifo_out = fifo_pair;

   // both ports advance together off one fifo entry; stall reaches upstream
   assign o_luma_valid = fifo_out_valid;
   assign o_selfpath_luma_port = {top_bit, fifo_out[22:0]};
   assign o_chroma_valid = fifo_out_valid && fifo_out[31];
   assign o_selfpath_chroma_port = fifo_out[31] ? fifo_out[30:23] : 8'h00;
endmodule // ycr_converter

// ---- ycr_pkg.sv ----
// package: constants, modes and coefficients for the self-path ycbcr to rgb converter
package ycr_pkg;
   // output format select
   typedef enum logic [1:0] {YCR_MODE_BYPASS, YCR_MODE_888, YCR_MODE_666, YCR_MODE_565} ycr_mode_t;
   // fixed point coefficients, scale 2^10
   localparam int YCR_FRAC = 10;
   localparam logic signed [12:0] YCR_K_Y = 13'sd1192;    // 1.164
   localparam logic signed [12:0] YCR_K_RCR = 13'sd1634;  // 1.596
   localparam logic signed [12:0] YCR_K_GCR = 13'sd833;   // 0.813
   localparam logic signed [12:0] YCR_K_GCB = 13'sd400;   // 0.391
   localparam logic signed [12:0] YCR_K_BCB = 13'sd2066;  // 2.018
   localparam logic signed [9:0] YCR_Y_OFS = 10'sd16;
   localparam logic signed [9:0] YCR_C_OFS = 10'sd128;
   localparam logic signed [23:0] YCR_ROUND = 24'sd512;
   localparam logic signed [23:0] YCR_MAX = 24'sd255;
   localparam logic [7:0] YCR_CHROMA_RST = 8'h80;
   localparam int YCR_FIFO_DEPTH = 4;
endpackage

// ---- ycr_fifo.sv ----
// small valid/ready fifo used in front of the memory write unit
`timescale 1ns/1ns
module ycr_fifo #(
   parameter int WIDTH = 32,
   parameter int DEPTH = 4
)(
   input wire logic i_clk_sys,
   input wire logic i_rst_b,
   input wire logic i_in_valid,
   output logic o_in_ready,
   input wire logic [WIDTH-1:0] i_in_data,
   output logic o_out_valid,
   input wire logic i_out_ready,
   output logic [WIDTH-1:0] o_out_data
);
   localparam int AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
   initial
   begin
      if (DEPTH < 2 || (DEPTH & (DEPTH - 1)) != 0) $error("depth must be a power of two >= 2");
   end
   logic [WIDTH-1:0] mem_r [DEPTH];
   logic [AW-1:0] wr_r;
   logic [AW-1:0] rd_r;
   logic [AW:0] cnt_r;
   wire push = i_in_valid && o_in_ready;
   wire pop = o_out_valid && i_out_ready;
   // honest full and empty from the occupancy count
   assign o_in_ready = (cnt_r != (AW+1)'(DEPTH));
   assign o_out_valid = (cnt_r != '0);
   assign o_out_data = mem_r[rd_r];
   // storage, no reset needed on data
   always_ff @(posedge i_clk_sys)
   begin
      if (push) mem_r[wr_r] <= i_in_data;
   end
   // pointers and count
   always_ff @(posedge i_clk_sys or negedge i_rst_b)
   begin
      if (!i_rst_b)
      begin
         wr_r <= '0;
         rd_r <= '0;
         cnt_r <= '0;
      end
      else
      begin
         if (push) wr_r <= wr_r + 1'b1;
         if (pop) rd_r <= rd_r + 1'b1;
         cnt_r <= cnt_r + (AW+1)'(push) - (AW+1)'(pop);
      end
   end
endmodule // ycr_fifo

// ---- ycr_assertions.sv ----
// checker on the converter ports
`timescale 1ns/1ns
module ycr_checker import ycr_pkg::*; (
   input wire logic i_clk_sys, i_rst_b, i_in_valid, o_in_ack, o_luma_valid, i_luma_ack, o_chroma_valid,
   input wire ycr_mode_t i_mode,
   input wire logic [23:0] o_selfpath_luma_port,
   input wire logic [7:0] o_selfpath_chroma_port);
   // one domain; mode only moves while empty, so it tags the queued words
   default clocking cb @(posedge i_clk_sys); endclocking
   default disable iff (!i_rst_b);
   chk_stall_hold: assert property (o_luma_valid && !i_luma_ack |=> $stable(o_selfpath_luma_port))
      else $error("stalled word moved");
   chk_take_show: assert property (i_in_valid && o_in_ack |=> o_luma_valid) else $error("no output");
   chk_full_stay: assert property (!o_in_ack && !i_luma_ack |=> !o_in_ack) else $error("full lost");
   chk_chroma_with: assert property (o_chroma_valid |-> o_luma_valid) else $error("lone chroma");
   chk_rgb_quiet: assert property (i_mode != YCR_MODE_BYPASS |-> !o_chroma_valid) else $error("chroma on");
   chk_byp_pair: assert property (o_luma_valid && i_mode == YCR_MODE_BYPASS |-> o_chroma_valid)
      else $error("no chroma");
   chk_565_low: assert property (o_luma_valid && i_mode == YCR_MODE_565 |-> !o_selfpath_luma_port[23:16])
      else $error("565 top");
   chk_666_low: assert property (o_luma_valid && i_mode == YCR_MODE_666 |-> !o_selfpath_luma_port[23:18])
      else $error("666 top");
   // main scenarios
   cover property (!o_in_ack);
   cover property (o_chroma_valid && i_luma_ack);
   cover property (o_luma_valid && !i_luma_ack ##1 i_luma_ack);
endmodule // ycr_checker
bind ycr_converter ycr_checker u_chk (.*);

// ---- ycr_sink.sv ----
// partner: memory write unit acknowledge
`timescale 1ns/1ns
module ycr_sink (
   input wire logic i_clk_sys,
   input wire logic i_hold,
   output logic o_ack);
   // random stalls just after the edge; hold forces a long one
   initial o_ack = 1'b0;
   always @(posedge i_clk_sys) o_ack <= #1 !i_hold && ($urandom_range(3) != 0);
endmodule // ycr_sink

// ---- ycr_converter_tb.sv ----
// bench: random pixels in every mode against an integer model
`timescale 1ns/1ns
module ycr_converter_tb;
   import ycr_pkg::*;
   logic i_clk_sys = 0, i_rst_b = 0, i_in_valid = 0, i_in_cr_phase = 0, hold = 0, o_in_ack, o_luma_valid;
   logic i_luma_ack, o_chroma_valid;
   logic [7:0] i_in_luma = 0, i_in_chroma = 0, o_selfpath_chroma_port;
   logic [23:0] o_selfpath_luma_port;
   logic [32:0] q[$];
   ycr_mode_t i_mode = YCR_MODE_BYPASS;
   int errors = 0, checks = 0, h[2] = '{128, 128};
   ycr_converter u_dut (.*);
   ycr_sink u_sink (.i_clk_sys(i_clk_sys), .i_hold(hold), .o_ack(i_luma_ack));
   initial forever #25 i_clk_sys = ~i_clk_sys; // 20 mhz
   // round half up, clamp to a byte
   function automatic logic [7:0] sat(int s);
      s = (s + 512) >>> 10;
      return (s < 0) ? 8'h00 : (s > 255) ? 8'hff : 8'(s);
   endfunction
   // expected {bypass, chroma, word}; h holds cb and cr across the pair
   function automatic logic [32:0] model(ycr_mode_t m, int y, int c, logic p);
      logic [7:0] r, g, b;
      h[p] = c;
      r = sat((y - 16) * 1192 + 1634 * (h[1] - 128));
      g = sat((y - 16) * 1192 - 833 * (h[1] - 128) - 400 * (h[0] - 128));
      b = sat((y - 16) * 1192 + 2066 * (h[0] - 128));
      case (m)
         YCR_MODE_888: return {9'h000, r, g, b};
         YCR_MODE_666: return {15'h0000, r[7:2], g[7:2], b[7:2]};
         YCR_MODE_565: return {17'h00000, r[7:3], g[7:2], b[7:3]};
         default: return {1'b1, 8'(c), 16'h0000, 8'(y)};
      endcase
   endfunction
   task automatic check(logic [32:0] got, exp);
      checks++;
      errors += int'(got !== exp);
      if (got !== exp) $display("wrong value at %0t: %h expected %h", $time, got, exp);
   endtask
   // model each take, compare each pop
   always @(posedge i_clk_sys)
   begin
      if (i_in_valid && o_in_ack) q.push_back(model(i_mode, i_in_luma, i_in_chroma, i_in_cr_phase));
      if (o_luma_valid && i_luma_ack) check({o_chroma_valid, o_selfpath_chroma_port, o_selfpath_luma_port}, q.pop_front());
   end
   // valid held until the accepting edge
   task automatic send(int n);
      repeat (n)
      begin
         #1 i_in_valid = 1;
         {i_in_luma, i_in_chroma} = 16'($urandom);
         i_in_cr_phase = !i_in_cr_phase;
         // ack read settled between edges; it only moves on an edge
         while (o_in_ack !== 1'b1)
         begin
            @(posedge i_clk_sys);
            #1;
         end
         @(posedge i_clk_sys);
      end
      #1 i_in_valid = 0;
   endtask
   // per mode: fill while stalled, then stream and drain
   initial
   begin
      void'($urandom(32'hc045));
      repeat (20) @(posedge i_clk_sys);
      #1 i_rst_b = 1;
      for (int m = 0; m < 4; m++)
      begin
         i_mode = ycr_mode_t'(m);
         hold = 1;
         repeat (2) @(posedge i_clk_sys);
         send(YCR_FIFO_DEPTH);
         check(33'(o_in_ack), 33'h0);
         hold = 0;
         send(40);
         repeat (300) if (q.size() != 0) @(posedge i_clk_sys);
         check(33'(q.size()), 33'h0);
         @(posedge i_clk_sys) #1;
      end
      print_verdict(0);
   end
   initial #2000000 print_verdict(1); // watchdog, far past the run
   task automatic print_verdict(int late);
      errors += late;
      $display("errors %0d checks %0d", errors, checks);
      if (errors == 0 && checks > 0) $display("Run complete: PASS");
      else $display("Run complete: FAIL");
      $finish;
   endtask
endmodule // ycr_converter_tb
